/* File: design/vsd_decoder.sv */
// serial control decoder: shift register, load strobe, level registers
// assumes the serial pins are asynchronous to clk_sys and at least
// several times slower, so every edge is seen as a stable level change
// load_strobe_n may be tied to shift_enable_n by a 3-wire host
`timescale 1ns/100ps
module vsd_decoder
  import vsd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        shift_enable_n,
  input  wire logic        load_strobe_n,
  output vsd_levels_type   levels,
  output logic [SEL_W-1:0] target_sel
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  vsd_link_type   link_pins;
  vsd_link_type   sync1_ff;
  vsd_link_type   sync2_ff;
  vsd_link_type   prev_ff;

  assign link_pins = '{sclk:       serial_clk,
                       sdata:      serial_data,
                       shift_en_n: shift_enable_n,
                       load_n:     load_strobe_n};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= LINK_IDLE;
      sync2_ff <= LINK_IDLE;
      prev_ff  <= LINK_IDLE;
    end else begin
      sync1_ff <= link_pins;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // ---------------------------------------------------------------
  // edge detection and shift register
  // ---------------------------------------------------------------
  logic              sclk_fall;
  logic              shift_go;
  logic              load_rise;
  logic [BYTE_W-1:0] shift_ff;
  logic [BYTE_W-1:0] nxt_shift;

  assign sclk_fall = prev_ff.sclk & ~sync2_ff.sclk;
  assign shift_go  = sclk_fall & ~sync2_ff.shift_en_n;
  assign load_rise = ~prev_ff.load_n & sync2_ff.load_n;

  // msb first shift
  // data travels the same two stages as the clock, so they stay aligned
  assign nxt_shift = shift_go ? {shift_ff[BYTE_W-2:0], sync2_ff.sdata}
                              : shift_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= SHIFT_RST;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // ---------------------------------------------------------------
  // byte decode and level registers
  // ---------------------------------------------------------------
  logic             is_addr;
  logic             take_addr;
  logic             take_data;
  logic             sel_live;
  logic [SEL_W-1:0] ch_idx;
  logic [SEL_W-1:0] sel_ff;
  logic [SEL_W-1:0] nxt_sel;
  vsd_levels_type   levels_ff;
  vsd_levels_type   nxt_levels;

  // flag bit tells address from data
  assign is_addr   = shift_ff[FLAG_BIT];
  // transfer only on load rising edge
  assign take_addr = load_rise & is_addr;
  assign take_data = load_rise & ~is_addr;
  assign sel_live  = take_data & (sel_ff != SEL_NONE);
  assign ch_idx    = sel_ff - SEL_CH1;
  // low three bits pick the target
  assign nxt_sel   = take_addr ? shift_ff[SEL_W-1:0] : sel_ff;

  always_comb begin
    nxt_levels = levels_ff;
    if (sel_live) begin
      nxt_levels.mute_release = shift_ff[MUTE_BIT];
      if (sel_ff == SEL_MASTER) begin
        nxt_levels.master = shift_ff[MASTER_W-1:0];
      end else begin
        nxt_levels.chan[ch_idx] = shift_ff[CHAN_W-1:0];
      end
    end
  end

  // power-up state is muted with deepest attenuation; the target
  // starts at none so a stray data byte before any address is dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_ff                 <= SEL_NONE;
      levels_ff.mute_release <= MUTE_RST;
      levels_ff.master       <= MASTER_RST;
      levels_ff.chan         <= {NUM_CH{CHAN_RST}};
    end else begin
      sel_ff    <= nxt_sel;
      levels_ff <= nxt_levels;
    end
  end

  assign levels     = levels_ff;
  assign target_sel = sel_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_data_load;
    take_data ##0 (sel_ff != SEL_NONE);
  endsequence

  sequence s_addr_then_load;
    take_addr ##1 (!load_rise) [*1];
  endsequence

  sequence s_master_load;
    s_data_load ##0 (sel_ff == SEL_MASTER);
  endsequence

  sequence s_chan_load;
    s_data_load ##0 vsd_is_channel(sel_ff);
  endsequence

  // a live data byte may move at most the one channel it selects;
  // compared against the next state so the check sees the same cycle
  logic [NUM_CH-1:0] chan_moved;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_moved
    assign chan_moved[g] = (nxt_levels.chan[g] != levels_ff.chan[g]);
  end

  a_shift_msb_first: assert property (
    shift_go |=> shift_ff == {$past(shift_ff[BYTE_W-2:0]),
                              $past(sync2_ff.sdata)})
    else $error("shift register did not take bit at lsb");

  a_shift_hold_idle: assert property (
    sync2_ff.shift_en_n [*2] |=> $stable(shift_ff))
    else $error("shift register moved while enable high");

  a_levels_only_load: assert property (
    !$stable(levels_ff) |-> $past(load_rise))
    else $error("levels changed without load rising edge");

  a_master_update: assert property (
    s_data_load ##0 (sel_ff == SEL_MASTER)
      |=> levels_ff.master == $past(shift_ff[MASTER_W-1:0]))
    else $error("master level not taken from data byte");

  a_channel_update: assert property (
    s_data_load ##0 vsd_is_channel(sel_ff)
      |=> levels_ff.chan[$past(ch_idx)] == $past(shift_ff[CHAN_W-1:0])
          && levels_ff.master == $past(levels_ff.master))
    else $error("channel level not taken from data byte");

  a_address_capture: assert property (
    s_addr_then_load |-> sel_ff == $past(shift_ff[SEL_W-1:0], 1)
                         && $stable(levels_ff))
    else $error("address byte not captured or touched levels");

  a_mute_follow: assert property (
    s_data_load |=> levels_ff.mute_release == $past(shift_ff[MUTE_BIT]))
    else $error("mute release bit not taken");

  a_none_ignored: assert property (
    take_data && sel_ff == SEL_NONE |=> $stable(levels_ff))
    else $error("data after no-target address changed levels");

  a_shift_needs_fall: assert property (
    !shift_go |=> $stable(shift_ff))
    else $error("shift register moved without a serial clock fall");

  a_target_hold: assert property (
    !take_addr |=> $stable(sel_ff))
    else $error("target changed without an address load");

  a_mute_only_live: assert property (
    !sel_live |=> $stable(levels_ff.mute_release))
    else $error("mute release moved without a live data byte");

  a_mute_release_needs_bit: assert property (
    $rose(levels_ff.mute_release) |-> $past(shift_ff[MUTE_BIT]))
    else $error("mute released by a byte without its release bit");

  a_master_keeps_chan: assert property (
    s_master_load |=> $stable(levels_ff.chan))
    else $error("master update disturbed a channel level");

  a_one_chan_moves: assert property (
    $onehot0(chan_moved))
    else $error("more than one channel level moved at once");

  a_chan_move_live: assert property (
    (|chan_moved) |-> s_chan_load)
    else $error("channel level moved without a channel data byte");

endmodule

/* File: design/vsd_pkg.sv */
// constants, carrier types and helpers for the volume serial decoder
// assumes the serial pins are sampled by a faster system clock
// Function
// - master level is a 7-bit attenuation code, 7f is unity, 00 deepest
// - each of six channel levels is a 5-bit gain code, 0 to 31 dB
// - address byte has msb one; low three bits pick master, channel, none
// - data byte has msb zero; next bit releases mute; low bits are level
// - shift msb first on serial clock falling edge while enable is low
// - register contents move to holding levels only on load rising edge
package vsd_pkg;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int BYTE_W   = 8;
  localparam int MASTER_W = 7;
  localparam int CHAN_W   = 5;
  localparam int NUM_CH   = 6;
  localparam int SEL_W    = 3;
  localparam int FLAG_BIT = 7;
  localparam int MUTE_BIT = 6;

  // ---------------------------------------------------------------
  // target selection codes and reset values
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0]    SEL_MASTER = 3'h0;
  localparam logic [SEL_W-1:0]    SEL_CH1    = 3'h1;
  localparam logic [SEL_W-1:0]    SEL_NONE   = 3'h7;
  localparam logic [MASTER_W-1:0] MASTER_RST = 7'h00;
  localparam logic [CHAN_W-1:0]   CHAN_RST   = 5'h00;
  localparam logic                MUTE_RST   = 1'h0;
  localparam logic [BYTE_W-1:0]   SHIFT_RST  = 8'h00;

  typedef struct packed {
    logic                           mute_release;
    logic [MASTER_W-1:0]            master;
    logic [NUM_CH-1:0][CHAN_W-1:0]  chan;
  } vsd_levels_type;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic shift_en_n;
    logic load_n;
  } vsd_link_type;

  // serial clock idles low, enable and load idle high
  localparam vsd_link_type LINK_IDLE = 4'h3;

  function automatic logic vsd_is_channel(input logic [SEL_W-1:0] sel);
    vsd_is_channel = (sel != SEL_MASTER) && (sel != SEL_NONE);
  endfunction

endpackage

/* File: dv/tb_top.sv */
// bench for the level decoder: host model, level model, comparisons
// assumes the decoder takes a byte 3 to 4 cycles after the load rise
`timescale 1ns/100ps
module tb_top
  import vsd_pkg::*;
;
  logic             clk_sys = 1'b0;
  logic             arst_n = 1'b0;
  vsd_link_type     link;
  vsd_levels_type   levels;
  logic [SEL_W-1:0] target_sel;
  int               n_fail = 0;
  int               total_checks = 0;
  int               master, mute, tgt, sh, rnd;
  int               ch[NUM_CH];

  always #10 clk_sys = ~clk_sys;

  vsd_host host (.clk_sys(clk_sys), .link(link));

  vsd_decoder u_vsd_decoder (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .serial_clk    (link.sclk),
    .serial_data   (link.sdata),
    .shift_enable_n(link.shift_en_n),
    .load_strobe_n (link.load_n),
    .levels        (levels),
    .target_sel    (target_sel)
  );

  // ---------------------------------------------------------------
  // compare tasks and level model
  // ---------------------------------------------------------------
  task automatic chk_lv(input string w, input vsd_levels_type e);
    total_checks++;
    if (levels !== e) begin
      n_fail++;
      $display("MISMATCH %s levels exp %h got %h", w, e, levels);
    end
  endtask

  task automatic chk_sel(input string w, input logic [2:0] e);
    total_checks++;
    if (target_sel !== e) begin
      n_fail++;
      $display("MISMATCH %s target exp %h got %h", w, e, target_sel);
    end
  endtask

  task automatic check(input string w);
    vsd_levels_type e;
    e.mute_release = mute[0];
    e.master = master[6:0];
    for (int i = 0; i < NUM_CH; i++) e.chan[i] = ch[i][4:0];
    chk_lv(w, e);
    chk_sel(w, tgt[2:0]);
  endtask

  // only the shift register content counts at the load
  task automatic send(input logic [7:0] b, input logic en);
    host.shift(b, en);
    if (en) sh = b;
    check("held");
    host.load();
    if (sh[7]) tgt = sh[2:0];
    else if (tgt == 0) begin
      master = sh[6:0];
      mute = sh[6];
    end else if (tgt != 7) begin
      ch[tgt-1] = sh[4:0];
      mute = sh[6];
    end
    check("loaded");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] seq[$] = '{8'h25, 8'h80, 8'h7f, 8'h00, 8'h81, 8'h5f,
                           8'h50, 8'h4f, 8'h86, 8'h40};
    rnd = $urandom(32'h4bc3eccb);
    {master, mute, sh} = '0;
    tgt = 7;
    foreach (ch[i]) ch[i] = 0;
    repeat (4) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("reset");
    foreach (seq[i]) send(seq[i], 1'b1);
    for (int t = 0; t < 8; t++) begin
      send({1'b1, 4'($urandom), t[2:0]}, 1'b1);
      send({1'b0, 7'($urandom)}, 1'b1);
    end
    send(8'h82, 1'b1);
    send(8'hff, 1'b0);
    repeat (12) begin
      send({1'b1, 7'($urandom)}, 1'b1);
      send({1'b0, 7'($urandom)}, 1'b1);
    end
    results();
  end

  // a hang counts as a mismatch
  initial begin
    #1000000;
    n_fail++;
    results();
  end
endmodule

/* File: dv/vsd_host.sv */
// host model: drives the four serial pins of the level decoder
// assumes clk_sys is the bench clock; each link level lasts at least 4 cycles
`timescale 1ns/100ps
module vsd_host
  import vsd_pkg::*;
(
  input  wire logic    clk_sys,
  output vsd_link_type link
);
  initial link = LINK_IDLE;

  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // msb first; data moves with the rising serial clock so it
  // stays steady on both sides of the falling edge that samples it
  task automatic shift(input logic [7:0] b, input logic en);
    link.shift_en_n = ~en;
    link.load_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link.sdata = b[i];
      link.sclk = 1'b1;
      half();
      link.sclk = 1'b0;
      half();
    end
  endtask

  // released data shows the inverse, so a stale bit never matches
  task automatic load();
    link.shift_en_n = 1'b1;
    link.load_n = 1'b1;
    link.sdata = ~link.sdata;
    half();
    half();
  endtask
endmodule
